/* File: common/rar_pkg.sv */
package rar_pkg;
	localparam int unsigned DATA_W            = 32;
	localparam int unsigned ADDR_W            = 8;

	// register indices; byte address is four times the index
	localparam logic [7:0]  IDX_RIGHT_ROUTE   = 8'h16;
	localparam logic [7:0]  IDX_SPARE         = 8'h17;
	localparam logic [7:0]  IDX_LEFT_ROUTE    = 8'h18;
	localparam logic [7:0]  IDX_BIAS          = 8'h19;
	localparam logic [7:0]  ADDR_RIGHT_ROUTE  = 8'(4 * IDX_RIGHT_ROUTE);
	localparam logic [7:0]  ADDR_SPARE        = 8'(4 * IDX_SPARE);
	localparam logic [7:0]  ADDR_LEFT_ROUTE   = 8'(4 * IDX_LEFT_ROUTE);
	localparam logic [7:0]  ADDR_BIAS         = 8'(4 * IDX_BIAS);

	// field positions within the routing and bias bytes
	localparam int unsigned BIT_DIFF          = 7;
	localparam int unsigned LVL_HI            = 6;
	localparam int unsigned LVL_LO            = 3;
	localparam int unsigned BIT_PWR           = 2;
	localparam int unsigned SS_HI             = 1;
	localparam int unsigned SS_LO             = 0;
	localparam int unsigned BIAS_HI           = 7;
	localparam int unsigned BIAS_LO           = 6;

	// reset values and codes
	localparam logic [7:0]  RST_SPARE         = 8'h78;
	localparam logic        RST_DIFF          = 1'h0;
	localparam logic [3:0]  RST_LVL           = 4'hF;
	localparam logic        RST_PWR           = 1'h0;
	localparam logic [1:0]  RST_SS            = 2'h0;
	localparam logic [1:0]  RST_BIAS          = 2'h0;
	localparam logic [3:0]  LVL_DISCONNECT    = 4'hF;
	localparam logic [3:0]  LVL_MAX_GAIN_CODE = 4'h8;
	localparam logic [1:0]  SS_EVERY_SAMPLE   = 2'h0;
	localparam logic [1:0]  SS_EVERY_TWO      = 2'h1;
	localparam logic [1:0]  BIAS_OFF          = 2'h0;
	localparam logic [1:0]  BIAS_2V0          = 2'h1;
	localparam logic [1:0]  BIAS_2V5          = 2'h2;
	localparam logic [1:0]  BIAS_SUPPLY       = 2'h3;
	localparam logic [2:0]  LEFT_RSVD_BITS    = 3'h0;
	localparam logic [5:0]  BIAS_RSVD_BITS    = 6'h00;
endpackage

/* File: core/rar_core.sv */
`timescale 1ns/100ps

// Notes on behaviour
// - right route bit7: single-ended or differential
// - level codes 0..8 give gain, connect input
// - level code 1111 disconnects input, reset default
// - right route bit2 powers right channel
// - soft-step: 00 each, 01 every two, else off
// - spare register reads 0x78, writes ignored
// - left route bit7: single-ended or differential
// - left level field same codes, 1111 disconnects
// - left route bits2..0 read zero, read-only
// - bias field: off, 2V, 2.5V, supply
// - bias register sits at index 25
module rar_core
	import rar_pkg::*;
#(
	parameter int unsigned P_ADDR_W = ADDR_W
) (
	input  wire logic                i_clk,
	input  wire logic                i_rst,
	input  wire logic                i_ce,
	input  wire logic                i_psel,
	input  wire logic                i_penable,
	input  wire logic                i_pwrite,
	input  wire logic [P_ADDR_W-1:0] i_paddr,
	input  wire logic [DATA_W-1:0]   i_pwdata,
	input  wire logic [3:0]          i_pstrb,
	output logic                     o_pready,
	output logic                     o_pslverr,
	output logic [DATA_W-1:0]        o_prdata,
	output logic                     o_right_diff,
	output logic [3:0]               o_right_level,
	output logic                     o_right_connect,
	output logic                     o_right_power_up,
	output logic [1:0]               o_softstep_mode,
	output logic                     o_softstep_en,
	output logic                     o_softstep_div2,
	output logic                     o_left_diff,
	output logic [3:0]               o_left_level,
	output logic                     o_left_connect,
	output logic [1:0]               o_bias_level,
	output logic                     o_bias_on
);

	function automatic logic addr_is(input logic [P_ADDR_W-1:0] a, input logic [7:0] target);
		addr_is = (a == P_ADDR_W'(target));
	endfunction

	// codes 0..8 connect the input to the mix, 1111 and reserved codes do not
	function automatic logic level_connects(input logic [3:0] lvl);
		level_connects = (lvl <= LVL_MAX_GAIN_CODE);
	endfunction

	logic              ack_d;
	logic              ack_q;
	logic [DATA_W-1:0] rdata_d;
	logic [DATA_W-1:0] rdata_q;
	logic              r_diff_d;
	logic              r_diff_q;
	logic [3:0]        r_lvl_d;
	logic [3:0]        r_lvl_q;
	logic              r_conn_d;
	logic              r_conn_q;
	logic              r_pwr_d;
	logic              r_pwr_q;
	logic [1:0]        ss_d;
	logic [1:0]        ss_q;
	logic              ss_en_d;
	logic              ss_en_q;
	logic              ss_div2_d;
	logic              ss_div2_q;
	logic              l_diff_d;
	logic              l_diff_q;
	logic [3:0]        l_lvl_d;
	logic [3:0]        l_lvl_q;
	logic              l_conn_d;
	logic              l_conn_q;
	logic [1:0]        bias_d;
	logic [1:0]        bias_q;
	logic              bias_on_d;
	logic              bias_on_q;

	logic              setup;
	logic              access_done;
	logic              wr;
	logic              sel_right;
	logic              sel_spare;
	logic              sel_left;
	logic              sel_bias;
	logic              mapped;

	// arms in the setup cycle, or in the access cycle when a low clock enable froze the setup edge
	assign setup       = i_psel && !ack_q;
	assign sel_right   = addr_is(i_paddr, ADDR_RIGHT_ROUTE);
	assign sel_spare   = addr_is(i_paddr, ADDR_SPARE);
	assign sel_left    = addr_is(i_paddr, ADDR_LEFT_ROUTE);
	assign sel_bias    = addr_is(i_paddr, ADDR_BIAS);
	assign mapped      = sel_right || sel_spare || sel_left || sel_bias;
	// read data is captured when armed, so the access phase waits only after a frozen setup edge or while the clock enable is low
	assign o_pready    = i_psel && i_penable && ack_q && i_ce;
	assign o_pslverr   = o_pready && !mapped;
	assign access_done = o_pready;
	assign wr          = access_done && i_pwrite && i_pstrb[0];

	// snapshot of the fields, so the read word cannot change during the access phase
	always_comb begin
		ack_d   = ack_q;
		rdata_d = rdata_q;
		if (setup) begin
			ack_d   = 1'h1;
			rdata_d = '0;
			if (sel_right) begin
				rdata_d[7:0] = {r_diff_q, r_lvl_q, r_pwr_q, ss_q};
			end else if (sel_spare) begin
				rdata_d[7:0] = RST_SPARE;
			end else if (sel_left) begin
				rdata_d[7:0] = {l_diff_q, l_lvl_q, LEFT_RSVD_BITS};
			end else if (sel_bias) begin
				rdata_d[7:0] = {bias_q, BIAS_RSVD_BITS};
			end
		end else if (access_done) begin
			ack_d = 1'h0;
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			ack_q   <= 1'h0;
			rdata_q <= '0;
		end else if (i_ce) begin
			ack_q   <= ack_d;
			rdata_q <= rdata_d;
		end
	end

	assign o_prdata = rdata_q;

	// decodes are registered so the analog controls never see a decode glitch
	always_comb begin
		r_diff_d = r_diff_q;
		r_lvl_d  = r_lvl_q;
		r_pwr_d  = r_pwr_q;
		ss_d     = ss_q;
		l_diff_d = l_diff_q;
		l_lvl_d  = l_lvl_q;
		bias_d   = bias_q;
		if (wr && sel_right) begin
			r_diff_d = i_pwdata[BIT_DIFF];
			r_lvl_d  = i_pwdata[LVL_HI:LVL_LO];
			r_pwr_d  = i_pwdata[BIT_PWR];
			ss_d     = i_pwdata[SS_HI:SS_LO];
		end
		if (wr && sel_left) begin
			l_diff_d = i_pwdata[BIT_DIFF];
			l_lvl_d  = i_pwdata[LVL_HI:LVL_LO];
		end
		if (wr && sel_bias) begin
			bias_d = i_pwdata[BIAS_HI:BIAS_LO];
		end
		r_conn_d  = level_connects(r_lvl_d);
		l_conn_d  = level_connects(l_lvl_d);
		ss_en_d   = (ss_d == SS_EVERY_SAMPLE) || (ss_d == SS_EVERY_TWO);
		ss_div2_d = (ss_d == SS_EVERY_TWO);
		bias_on_d = (bias_d != BIAS_OFF);
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		// reset leaves both inputs disconnected and the right channel powered down
		if (i_rst) begin
			r_diff_q  <= RST_DIFF;
			r_lvl_q   <= RST_LVL;
			r_conn_q  <= 1'h0;
			r_pwr_q   <= RST_PWR;
			ss_q      <= RST_SS;
			ss_en_q   <= 1'h1;
			ss_div2_q <= 1'h0;
			l_diff_q  <= RST_DIFF;
			l_lvl_q   <= RST_LVL;
			l_conn_q  <= 1'h0;
			bias_q    <= RST_BIAS;
			bias_on_q <= 1'h0;
		end else if (i_ce) begin
			r_diff_q  <= r_diff_d;
			r_lvl_q   <= r_lvl_d;
			r_conn_q  <= r_conn_d;
			r_pwr_q   <= r_pwr_d;
			ss_q      <= ss_d;
			ss_en_q   <= ss_en_d;
			ss_div2_q <= ss_div2_d;
			l_diff_q  <= l_diff_d;
			l_lvl_q   <= l_lvl_d;
			l_conn_q  <= l_conn_d;
			bias_q    <= bias_d;
			bias_on_q <= bias_on_d;
		end
	end

	assign o_right_diff     = r_diff_q;
	assign o_right_level    = r_lvl_q;
	assign o_right_connect  = r_conn_q;
	assign o_right_power_up = r_pwr_q;
	assign o_softstep_mode  = ss_q;
	assign o_softstep_en    = ss_en_q;
	assign o_softstep_div2  = ss_div2_q;
	assign o_left_diff      = l_diff_q;
	assign o_left_level     = l_lvl_q;
	assign o_left_connect   = l_conn_q;
	assign o_bias_level     = bias_q;
	assign o_bias_on        = bias_on_q;

	// helpers sampled by the checks below
	logic        w_diff;
	logic [3:0]  w_lvl;
	logic        w_pwr;
	logic [1:0]  w_bias;
	logic [1:0]  w_ss;
	logic [14:0] cfg_all;
	logic        rd_done;

	assign w_diff  = i_pwdata[BIT_DIFF];
	assign w_lvl   = i_pwdata[LVL_HI:LVL_LO];
	assign w_pwr   = i_pwdata[BIT_PWR];
	assign w_bias  = i_pwdata[BIAS_HI:BIAS_LO];
	assign w_ss    = i_pwdata[SS_HI:SS_LO];
	assign cfg_all = {o_right_diff, o_right_level, o_right_power_up, o_softstep_mode,
		o_left_diff, o_left_level, o_bias_level};
	assign rd_done = access_done && !i_pwrite;

	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (i_rst);

	right_diff_a: assert property (wr && sel_right |=> o_right_diff == $past(w_diff))
		else $error("right differential bit not stored");
	right_conn_a: assert property (o_right_connect == (o_right_level <= LVL_MAX_GAIN_CODE))
		else $error("right connect does not follow level code");
	right_disc_a: assert property (wr && sel_right && w_lvl == LVL_DISCONNECT |=> !o_right_connect)
		else $error("right input connected with code 1111");
	power_up_a: assert property (wr && sel_right |=> o_right_power_up == $past(w_pwr) && $stable(o_bias_level))
		else $error("right power bit not stored");
	softstep_a: assert property (o_softstep_en == !o_softstep_mode[1] &&
		o_softstep_div2 == (o_softstep_mode == SS_EVERY_TWO))
		else $error("soft-step decode wrong");
	spare_keep_a: assert property (rd_done && sel_spare |-> o_prdata == DATA_W'(RST_SPARE))
		else $error("spare register does not read 0x78");
	left_diff_a: assert property (wr && sel_left |=> o_left_diff == $past(w_diff) &&
		o_left_level == $past(w_lvl))
		else $error("left route fields not stored");
	left_conn_a: assert property (o_left_connect == (o_left_level <= LVL_MAX_GAIN_CODE))
		else $error("left connect does not follow level code");
	left_rsvd_a: assert property (rd_done && sel_left |-> o_prdata[2:0] == LEFT_RSVD_BITS &&
		o_prdata[7:3] == {o_left_diff, o_left_level})
		else $error("left reserved bits not zero");
	bias_level_a: assert property (wr && sel_bias |=> o_bias_level == $past(w_bias) &&
		o_bias_on == ($past(w_bias) != BIAS_OFF))
		else $error("bias level not stored or decoded");
	bias_addr_a: assert property (rd_done && i_paddr == P_ADDR_W'(4 * 25) |->
		o_prdata == DATA_W'({o_bias_level, BIAS_RSVD_BITS}))
		else $error("bias register not at index 25");
	read_back_a: assert property (rd_done && sel_right |->
		o_prdata == DATA_W'({o_right_diff, o_right_level, o_right_power_up, o_softstep_mode}))
		else $error("right route read-back mismatch");
	no_wait_a: assert property (setup && i_ce ##1 i_psel && i_penable && i_ce |-> o_pready)
		else $error("access phase not answered at once");

	// stored fields and read-back
	right_lvl_a: assert property (wr && sel_right |=> o_right_level == $past(w_lvl))
		else $error("right level code not stored");
	softstep_st_a: assert property (wr && sel_right |=> o_softstep_mode == $past(w_ss))
		else $error("soft-step mode not stored");
	left_disc_a: assert property (wr && sel_left && w_lvl == LVL_DISCONNECT |=> !o_left_connect)
		else $error("left input connected with code 1111");
	bias_on_a: assert property (o_bias_on == (o_bias_level != BIAS_OFF))
		else $error("bias enable does not follow level");
	bias_rsvd_a: assert property (rd_done && sel_bias |-> o_prdata[5:0] == BIAS_RSVD_BITS)
		else $error("bias reserved bits not zero");
	err_read_a: assert property (rd_done && !mapped |-> o_prdata == '0 && o_pslverr)
		else $error("unmapped read not refused");
	rst_values_a: assert property (@(posedge i_clk) disable iff (1'h0) $fell(i_rst) |->
		!o_right_connect && !o_left_connect && !o_right_power_up && o_bias_level == RST_BIAS)
		else $error("fields not at reset values after reset");

	// refused writes must leave every field alone
	spare_wr_a: assert property (access_done && i_pwrite && sel_spare |=> $stable(cfg_all))
		else $error("spare write changed a field");
	strobe_a: assert property (access_done && i_pwrite && !i_pstrb[0] |=> $stable(cfg_all))
		else $error("write without byte strobe changed a field");
	unmapped_wr_a: assert property (access_done && i_pwrite && !mapped |=> $stable(cfg_all))
		else $error("unmapped write changed a field");

	// bus timing and clock enable
	freeze_a: assert property (!i_ce |=> $stable(cfg_all) && $stable(o_prdata))
		else $error("state changed while clock enable low");
	done_clears_a: assert property (access_done |=> !o_pready)
		else $error("ready repeated after completion");

	wr_right_c: cover property (wr && sel_right && w_lvl <= LVL_MAX_GAIN_CODE ##1 o_right_connect);
	rd_spare_c: cover property (rd_done && sel_spare);
	wr_bias_c: cover property (wr && sel_bias && w_bias == BIAS_SUPPLY);
	err_c: cover property (o_pslverr);
	frozen_setup_c: cover property (i_psel && i_penable && !ack_q && i_ce);

endmodule

/* File: dv/rar_core_test.sv */
`timescale 1ns/100ps
module rar_core_test;
	import rar_pkg::*;
	logic        clk        = 1'b0;
	logic        rst        = 1'b1;
	logic        ce         = 1'b1;
	logic        psel       = 1'b0;
	logic        penable    = 1'b0;
	logic        pwrite     = 1'b0;
	logic [7:0]  paddr      = 8'h00;
	logic [31:0] pwdata     = 32'h0;
	logic [3:0]  pstrb      = 4'hF;
	logic        pready, pslverr, r_diff, r_conn, r_pwr, ss_en, ss_div2, l_diff, l_conn, b_on;
	logic [31:0] prdata;
	logic [3:0]  r_lvl, l_lvl;
	logic [1:0]  ss_mode, b_lvl;
	logic [7:0]  mr         = 8'h78;
	logic [7:0]  ml         = 8'h78;
	logic [7:0]  mb         = 8'h00;
	logic [3:0]  lvl_tbl [10] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'hF};
	int          n_mismatch = 0;
	int          cmp_count  = 0;
	int          seed       = 32'h03615C36;

	always #12.5 clk = ~clk;

	rar_core rar_core_i (.i_clk(clk), .i_rst(rst), .i_ce(ce), .i_psel(psel), .i_penable(penable),
		.i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .i_pstrb(pstrb), .o_pready(pready),
		.o_pslverr(pslverr), .o_prdata(prdata), .o_right_diff(r_diff), .o_right_level(r_lvl),
		.o_right_connect(r_conn), .o_right_power_up(r_pwr), .o_softstep_mode(ss_mode),
		.o_softstep_en(ss_en), .o_softstep_div2(ss_div2), .o_left_diff(l_diff), .o_left_level(l_lvl),
		.o_left_connect(l_conn), .o_bias_level(b_lvl), .o_bias_on(b_on));

	// expected config outputs, decoded from the model bytes
	function automatic logic [31:0] exp_out();
		return {12'h0, mr[7], mr[6:3], mr[6:3] <= 4'h8, mr[2], mr[1:0], mr[1:0] < 2'h2, mr[1:0] == 2'h1,
			ml[7], ml[6:3], ml[6:3] <= 4'h8, mb[7:6], mb[7:6] != 2'h0};
	endfunction

	function automatic logic [31:0] got_out();
		return {12'h0, r_diff, r_lvl, r_conn, r_pwr, ss_mode, ss_en, ss_div2, l_diff, l_lvl, l_conn, b_lvl, b_on};
	endfunction

	task automatic finish_test();
		$display("counts: compares=%0d mismatches=%0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		cmp_count++;
		if (g !== e) begin
			n_mismatch++;
			$display("ERROR t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
		output logic [31:0] r, output logic e);
		int n;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		pstrb <= s;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 40);
		if (pready !== 1'b1) begin
			n_mismatch++;
			$display("ERROR t=%0t timeout pready=%h exp=%h", $time, pready, 1'b1);
			finish_test();
		end
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask

	function automatic logic unmapped(input logic [7:0] a);
		return !(a inside {ADDR_RIGHT_ROUTE, ADDR_SPARE, ADDR_LEFT_ROUTE, ADDR_BIAS});
	endfunction

	task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [3:0] s = 4'hF);
		logic [31:0] r;
		logic        e;
		apb(1'b1, a, {24'h0, d}, s, r, e);
		chk({31'h0, e}, {31'h0, unmapped(a)});
		if (s[0] && a == ADDR_RIGHT_ROUTE) mr = d;
		if (s[0] && a == ADDR_LEFT_ROUTE) ml = d;
		if (s[0] && a == ADDR_BIAS) mb = d;
		chk(got_out(), exp_out());
	endtask

	task automatic rd(input logic [7:0] a);
		logic [31:0] r;
		logic        e;
		logic [7:0]  x;
		apb(1'b0, a, 32'h0, 4'h0, r, e);
		x = (a == ADDR_RIGHT_ROUTE) ? mr : (a == ADDR_SPARE) ? RST_SPARE :
			(a == ADDR_LEFT_ROUTE) ? (ml & 8'hF8) : (a == ADDR_BIAS) ? (mb & 8'hC0) : 8'h00;
		chk(r, {24'h0, x});
		chk({31'h0, e}, {31'h0, unmapped(a)});
	endtask

	initial begin
		logic [31:0] v;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		chk(got_out(), exp_out());
		rd(ADDR_RIGHT_ROUTE);
		rd(ADDR_SPARE);
		rd(ADDR_LEFT_ROUTE);
		rd(ADDR_BIAS);
		$display("test reset done");
		for (int i = 0; i < 24; i++) begin
			v = $random(seed);
			wr(ADDR_RIGHT_ROUTE, {v[7], lvl_tbl[i % 10], v[2], 2'(i)});
			rd(ADDR_RIGHT_ROUTE);
			// the left input feeds only the right mix here, so its mode has no twin to match
			wr(ADDR_LEFT_ROUTE, {v[9], lvl_tbl[(i + 3) % 10], 3'h0});
			rd(ADDR_LEFT_ROUTE);
		end
		$display("test routing done");
		for (int i = 0; i < 4; i++) begin
			wr(ADDR_BIAS, {2'(i), 6'h00});
			rd(ADDR_BIAS);
		end
		$display("test bias done");
		wr(ADDR_SPARE, 8'hA5);
		rd(ADDR_SPARE);
		wr(ADDR_RIGHT_ROUTE, 8'h00, 4'hE);
		rd(ADDR_RIGHT_ROUTE);
		wr(8'h68, 8'h11);
		rd(8'h68);
		rd(8'h00);
		$display("test refusals done");
		fork
			rd(ADDR_BIAS);
			begin
				@(posedge clk);
				ce <= 1'b0;
				repeat (3) @(posedge clk);
				ce <= 1'b1;
			end
		join
		// clock enable low across the setup edge: the slave must still answer
		ce <= 1'b0;
		fork
			rd(ADDR_RIGHT_ROUTE);
			begin
				repeat (2) @(posedge clk);
				ce <= 1'b1;
			end
		join
		$display("test stall done");
		rst <= 1'b1;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		mr = 8'h78;
		ml = 8'h78;
		mb = 8'h00;
		chk(got_out(), exp_out());
		rd(ADDR_RIGHT_ROUTE);
		$display("test second reset done");
		finish_test();
	end
endmodule
